// ==== logic/rla_lane.sv ====
`timescale 1ns/1ps
`default_nettype none

module rla_lane #(
  parameter int unsigned SPACING_W = 16,
  parameter int unsigned FERR_W    = 4
) (
  // Clock and reset
  input  wire logic                 mclk_i,
  input  wire logic                 rst_i,
  // Lane events from the receive datapath
  input  wire logic                 word_i,
  input  wire logic                 blk_lock_i,
  input  wire logic                 hdr_err_i,
  input  wire logic                 sync_lost_i,
  input  wire logic                 mrk_good_i,
  input  wire logic                 mrk_bad_i,
  input  wire logic [SPACING_W-1:0] spacing_i,
  // Lane status
  output logic                      blk_lock_o,
  output logic                      synced_o,
  output logic                      sync_err_o,
  output logic                      len_err_o,
  output logic                      rep_err_o,
  output logic                      mf_err_o,
  output logic [FERR_W-1:0]         ferr_cnt_o,
  output logic                      ferr_vld_o
);

  logic [SPACING_W-1:0] wcnt_q;
  logic                 seen_q;
  logic [2:0]           rep_q;
  logic [2:0]           win_q;
  logic [FERR_W-1:0]    acc_q;

  wire mrk_any   = mrk_good_i | mrk_bad_i;
  wire lock_drop = ~blk_lock_i | sync_lost_i;
  wire overdue   = word_i & ~mrk_any & (wcnt_q == spacing_i);
  wire win_end   = (win_q == 3'(rla_pkg::FERR_WINDOW - 1));
  wire acc_full  = (acc_q == {FERR_W{1'b1}});
  wire [FERR_W-1:0] acc_d = acc_full ? acc_q : acc_q + FERR_W'(hdr_err_i);

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wcnt_q     <= '0;
      seen_q     <= 1'b0;
      rep_q      <= 3'h0;
      win_q      <= 3'h0;
      acc_q      <= '0;
      blk_lock_o <= 1'b0;
      synced_o   <= 1'b0;
      sync_err_o <= 1'b0;
      len_err_o  <= 1'b0;
      rep_err_o  <= 1'b0;
      mf_err_o   <= 1'b0;
      ferr_cnt_o <= '0;
      ferr_vld_o <= 1'b0;
    end
    else
    begin
      blk_lock_o <= blk_lock_i;
      mf_err_o   <= mrk_bad_i;
      if (mrk_any)
        wcnt_q <= '0;
      else if (word_i)
        wcnt_q <= wcnt_q + SPACING_W'(1);
      if (lock_drop)
        seen_q <= 1'b0;
      else if (mrk_any)
        seen_q <= 1'b1;
      if (lock_drop)
        len_err_o <= 1'b0;
      else if (mrk_any & seen_q)
        len_err_o <= (wcnt_q != spacing_i);
      else if (overdue & seen_q)
        len_err_o <= 1'b1;
      // four bad markers in a row
      if (lock_drop | mrk_good_i)
        rep_q <= 3'h0;
      else if (mrk_bad_i && rep_q != 3'(rla_pkg::REPEAT_LIMIT))
        rep_q <= rep_q + 3'h1;
      rep_err_o <= ~lock_drop & ~mrk_good_i &
                   ((rep_q == 3'(rla_pkg::REPEAT_LIMIT)) |
                    (mrk_bad_i &&
                     rep_q == 3'(rla_pkg::REPEAT_LIMIT - 1)));
      // locked and a good marker seen
      if (lock_drop)
        synced_o <= 1'b0;
      else if (mrk_good_i)
        synced_o <= 1'b1;
      if (sync_lost_i | (blk_lock_i & ~seen_q & overdue))
        sync_err_o <= 1'b1;
      else if (mrk_good_i & blk_lock_i)
        sync_err_o <= 1'b0;
      win_q <= win_end ? 3'h0 : win_q + 3'h1;
      acc_q <= win_end ? '0 : acc_d;
      ferr_vld_o <= win_end & (acc_d != '0);
      if (win_end)
        ferr_cnt_o <= acc_d;
    end
  end

endmodule : rla_lane

`default_nettype wire

// ==== logic/rla_pkg.sv ====
package rla_pkg;

  // Lane geometry.
  localparam int unsigned NUM_LANES     = 20;
  localparam int unsigned FERR_FIRST    = 16;
  localparam int unsigned FERR_LANES    = 4;
  localparam int unsigned FERR_W        = 4;
  localparam int unsigned SPACING_W     = 16;

  // Consecutive bad markers that raise the repeat error.
  localparam int unsigned REPEAT_LIMIT  = 4;
  // Cycles over which framing header errors are summed per report.
  localparam int unsigned FERR_WINDOW   = 8;

  // Register bus map, byte addresses.
  localparam int unsigned ADDR_W        = 8;
  localparam logic [7:0]  OFS_SPACING   = 8'h00;
  localparam logic [7:0]  OFS_BLOCK_LCK = 8'h04;
  localparam logic [7:0]  OFS_WORD_SYNC = 8'h08;
  localparam logic [7:0]  OFS_SYNC_ERR  = 8'h0c;
  localparam logic [7:0]  OFS_ALIGN     = 8'h10;

  // Bit positions in the alignment status register.
  localparam int unsigned ALN_ALIGNED   = 0;
  localparam int unsigned ALN_ERR       = 1;
  localparam int unsigned ALN_STATUS    = 2;
  localparam int unsigned ALN_LFAULT    = 3;

  // Reset values.
  localparam logic [15:0] RST_SPACING   = 16'h3fff;

  typedef enum logic [1:0] {
    RLA_ALN_IDLE = 2'b00,
    RLA_ALN_UP   = 2'b01,
    RLA_ALN_LOST = 2'b10
  } rla_aln_state_t;

endpackage : rla_pkg

// ==== logic/rla_status.sv ====
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Lanes 16 to 19 give a valid strobe with each nonzero 4-bit framing count.
// - Local fault is high when internal or received local fault is high.
// - Sync bit per lane is set once locked and a good lane marker arrived.
// - Sync vector matches management bits 3.52.7:0 and 3.53.11:0.
// - Sync error per lane on header framing loss or an overdue first lane marker after lock.
// - Length error holds while markers arrive off the spacing plus one.
// - Repeat error holds after four consecutive bad markers until cleared.
// - Marker word error pulses one cycle per malformed marker word.
// - Aligned is 1 only when every lane is aligned and de-skewed.
// - Aligned at 0 counts as a local fault on the receive path.
// - Aligned mirrors management bit 3.50.12.
// - PCS status is aligned and not in high bit error rate state.
// - Block lock vector mirrors bits 3.50.7:0 and 3.51.11:0.
// - Alignment error on an alignment fault or loss of earlier alignment.
module rla_status #(
  parameter int unsigned NUM_LANES = rla_pkg::NUM_LANES,
  parameter int unsigned SPACING_W = rla_pkg::SPACING_W,
  parameter int unsigned FERR_W    = rla_pkg::FERR_W
) (
  // Clock and reset
  input  wire logic                   mclk_i,
  input  wire logic                   rst_i,
  // Register port
  input  wire logic [rla_pkg::ADDR_W-1:0] reg_addr_i,
  input  wire logic [31:0]            reg_wdata_i,
  input  wire logic                   reg_wr_i,
  input  wire logic                   reg_rd_i,
  output logic      [31:0]            reg_rdata_o,
  // Per-lane events from the receive datapath
  input  wire logic [NUM_LANES-1:0]   lane_word_i,
  input  wire logic [NUM_LANES-1:0]   lane_blk_lock_i,
  input  wire logic [NUM_LANES-1:0]   lane_hdr_err_i,
  input  wire logic [NUM_LANES-1:0]   lane_sync_lost_i,
  input  wire logic [NUM_LANES-1:0]   lane_mrk_good_i,
  input  wire logic [NUM_LANES-1:0]   lane_mrk_bad_i,
  // Global events from the aligner and fault logic
  input  wire logic                   deskew_done_i,
  input  wire logic                   align_fault_i,
  input  wire logic                   hi_ber_i,
  input  wire logic                   int_fault_i,
  input  wire logic                   rcv_local_fault_i,
  // Per-lane status
  output logic      [NUM_LANES-1:0]   block_lock_o,
  output logic      [NUM_LANES-1:0]   lane_word_sync_vector_o,
  output logic      [NUM_LANES-1:0]   lane_word_sync_error_vector_o,
  output logic      [NUM_LANES-1:0]   lane_marker_interval_error_o,
  output logic      [NUM_LANES-1:0]   lane_marker_repeat_error_o,
  output logic      [NUM_LANES-1:0]   lane_marker_word_error_o,
  // Framing counts of the upper lanes
  output logic      [FERR_W-1:0]      ferr_cnt_16_o,
  output logic      [FERR_W-1:0]      ferr_cnt_17_o,
  output logic      [FERR_W-1:0]      ferr_cnt_18_o,
  output logic      [FERR_W-1:0]      ferr_cnt_19_o,
  output logic                        ferr_vld_16_o,
  output logic                        ferr_vld_17_o,
  output logic                        ferr_vld_18_o,
  output logic                        ferr_vld_19_o,
  // Link status
  output logic                        aligned_o,
  output logic                        aligned_err_o,
  output logic                        pcs_status_o,
  output logic                        local_fault_o
);

  // The lane fan-out and the register views assume the package geometry.
  if (NUM_LANES != rla_pkg::NUM_LANES || SPACING_W < 2 ||
      SPACING_W > 32 || FERR_W != rla_pkg::FERR_W)
  begin : g_bad_params
    $error("rla_status: unsupported parameter values");
  end

  logic [SPACING_W-1:0]   marker_spacing_minus_one_q;
  logic [FERR_W-1:0]      ferr_cnt [NUM_LANES];
  logic [NUM_LANES-1:0]   ferr_vld;
  rla_pkg::rla_aln_state_t aln_state_q;
  rla_pkg::rla_aln_state_t aln_state_d;

  // One tracker per lane; lanes below 16 leave their counts unread.
  genvar g;
  generate
    for (g = 0; g < NUM_LANES; g++)
    begin : g_lane
      rla_lane #(
        .SPACING_W (SPACING_W),
        .FERR_W    (FERR_W)
      ) u_lane (
        .mclk_i      (mclk_i),
        .rst_i       (rst_i),
        .word_i      (lane_word_i[g]),
        .blk_lock_i  (lane_blk_lock_i[g]),
        .hdr_err_i   (lane_hdr_err_i[g]),
        .sync_lost_i (lane_sync_lost_i[g]),
        .mrk_good_i  (lane_mrk_good_i[g]),
        .mrk_bad_i   (lane_mrk_bad_i[g]),
        .spacing_i   (marker_spacing_minus_one_q),
        .blk_lock_o  (block_lock_o[g]),
        .synced_o    (lane_word_sync_vector_o[g]),
        .sync_err_o  (lane_word_sync_error_vector_o[g]),
        .len_err_o   (lane_marker_interval_error_o[g]),
        .rep_err_o   (lane_marker_repeat_error_o[g]),
        .mf_err_o    (lane_marker_word_error_o[g]),
        .ferr_cnt_o  (ferr_cnt[g]),
        .ferr_vld_o  (ferr_vld[g])
      );
    end
  endgenerate

  assign ferr_cnt_16_o = ferr_cnt[16];
  assign ferr_cnt_17_o = ferr_cnt[17];
  assign ferr_cnt_18_o = ferr_cnt[18];
  assign ferr_cnt_19_o = ferr_cnt[19];
  assign ferr_vld_16_o = ferr_vld[16];
  assign ferr_vld_17_o = ferr_vld[17];
  assign ferr_vld_18_o = ferr_vld[18];
  assign ferr_vld_19_o = ferr_vld[19];

  wire all_synced = &lane_word_sync_vector_o;
  wire aligned_d  = all_synced & deskew_done_i & ~align_fault_i;

  // alignment faults, including loss after success
  always_comb
  begin
    aln_state_d = aln_state_q;
    case (aln_state_q)
      rla_pkg::RLA_ALN_IDLE:
        if (align_fault_i)
          aln_state_d = rla_pkg::RLA_ALN_LOST;
        else if (aligned_d)
          aln_state_d = rla_pkg::RLA_ALN_UP;
      rla_pkg::RLA_ALN_UP:
        if (!aligned_d)
          aln_state_d = rla_pkg::RLA_ALN_LOST;
      rla_pkg::RLA_ALN_LOST:
        if (aligned_d)
          aln_state_d = rla_pkg::RLA_ALN_UP;
      default:
        aln_state_d = rla_pkg::RLA_ALN_IDLE;
    endcase
  end

  wire aligned_err_d = (aln_state_d == rla_pkg::RLA_ALN_LOST);
  // aligned and not high bit error rate
  wire pcs_status_d  = aligned_d & ~hi_ber_i;
  // misalignment is an internal local fault
  wire int_local_flt = ~aligned_d | int_fault_i;
  wire local_fault_d = int_local_flt | rcv_local_fault_i;

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      aln_state_q   <= rla_pkg::RLA_ALN_IDLE;
      aligned_o     <= 1'b0;
      aligned_err_o <= 1'b0;
      pcs_status_o  <= 1'b0;
      local_fault_o <= 1'b1;
    end
    else
    begin
      aln_state_q   <= aln_state_d;
      aligned_o     <= aligned_d;
      aligned_err_o <= aligned_err_d;
      pcs_status_o  <= pcs_status_d;
      local_fault_o <= local_fault_d;
    end
  end

  // Register decode.
  wire sel_spacing = (reg_addr_i == rla_pkg::OFS_SPACING);
  wire sel_blk     = (reg_addr_i == rla_pkg::OFS_BLOCK_LCK);
  wire sel_sync    = (reg_addr_i == rla_pkg::OFS_WORD_SYNC);
  wire sel_serr    = (reg_addr_i == rla_pkg::OFS_SYNC_ERR);
  wire sel_align   = (reg_addr_i == rla_pkg::OFS_ALIGN);

  wire [31:0] rd_spacing = 32'(marker_spacing_minus_one_q);
  wire [31:0] rd_blk     = 32'(block_lock_o);
  wire [31:0] rd_sync    = 32'(lane_word_sync_vector_o);
  wire [31:0] rd_serr    = 32'(lane_word_sync_error_vector_o);
  wire [31:0] rd_align;
  assign rd_align = (32'(aligned_o)     << rla_pkg::ALN_ALIGNED) |
                    (32'(aligned_err_o) << rla_pkg::ALN_ERR)     |
                    (32'(pcs_status_o)  << rla_pkg::ALN_STATUS)  |
                    (32'(local_fault_o) << rla_pkg::ALN_LFAULT);

  // Unmapped addresses read as zero so software probing is harmless.
  wire [31:0] rd_mux = sel_spacing ? rd_spacing :
                       sel_blk     ? rd_blk     :
                       sel_sync    ? rd_sync    :
                       sel_serr    ? rd_serr    :
                       sel_align   ? rd_align   : 32'h0000_0000;

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      marker_spacing_minus_one_q <= SPACING_W'(rla_pkg::RST_SPACING);
      reg_rdata_o                <= 32'h0000_0000;
    end
    else
    begin
      if (reg_wr_i && sel_spacing)
        marker_spacing_minus_one_q <= reg_wdata_i[SPACING_W-1:0];
      reg_rdata_o <= reg_rd_i ? rd_mux : 32'h0000_0000;
    end
  end

endmodule : rla_status

`default_nettype wire

// ==== test/rla_status_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none

module rla_status_chk #(
  parameter int unsigned NUM_LANES = 20
) (
  input wire logic                      mclk_i,
  input wire logic                      rst_i,
  input wire logic [NUM_LANES-1:0]      lane_blk_lock_i,
  input wire logic [NUM_LANES-1:0]      lane_sync_lost_i,
  input wire logic [NUM_LANES-1:0]      lane_mrk_bad_i,
  input wire logic                      deskew_done_i,
  input wire logic                      hi_ber_i,
  input wire logic                      int_fault_i,
  input wire logic                      rcv_local_fault_i,
  input wire logic [NUM_LANES-1:0]      lane_word_sync_vector_o,
  input wire logic [NUM_LANES-1:0]      lane_word_sync_error_vector_o,
  input wire logic [NUM_LANES-1:0]      lane_marker_repeat_error_o,
  input wire logic [NUM_LANES-1:0]      lane_marker_word_error_o,
  input wire logic [rla_pkg::FERR_W-1:0] ferr_cnt_16_o,
  input wire logic                      ferr_vld_16_o,
  input wire logic                      aligned_o,
  input wire logic                      pcs_status_o,
  input wire logic                      local_fault_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  sequence s_bad_mark;
    $past(lane_mrk_bad_i[3]);
  endsequence

  sequence s_vld_once;
    (ferr_cnt_16_o != '0) ##1 !ferr_vld_16_o;
  endsequence

  a_fault_any: assert property (
    local_fault_o == (!aligned_o || $past(int_fault_i)
                      || $past(rcv_local_fault_i)))
    else $error("local fault does not follow its causes");
  a_status_and: assert property (
    pcs_status_o == (aligned_o && !$past(hi_ber_i)))
    else $error("pcs status wrong");
  a_sync_lock: assert property (
    (lane_word_sync_vector_o & ~$past(lane_blk_lock_i)) == '0)
    else $error("sync bit set on an unlocked lane");
  a_lost_err: assert property (
    (|$past(lane_sync_lost_i)) |->
    (($past(lane_sync_lost_i) & ~lane_word_sync_error_vector_o) == '0))
    else $error("sync loss did not raise sync error");
  a_mf_pulse: assert property (
    lane_marker_word_error_o == $past(lane_mrk_bad_i))
    else $error("marker word error pulse wrong");
  a_align_all: assert property (
    aligned_o |-> (&$past(lane_word_sync_vector_o) && $past(deskew_done_i)))
    else $error("aligned without all lanes synced");
  a_rep_rise: assert property (
    $rose(lane_marker_repeat_error_o[3]) |-> s_bad_mark)
    else $error("repeat error rose without a bad marker");
  a_ferr_pulse: assert property (
    ferr_vld_16_o |-> s_vld_once)
    else $error("framing valid strobe wrong");
endmodule : rla_status_chk

bind rla_status rla_status_chk #(.NUM_LANES(NUM_LANES)) u_chk (
  .mclk_i(mclk_i), .rst_i(rst_i), .lane_blk_lock_i(lane_blk_lock_i),
  .lane_sync_lost_i(lane_sync_lost_i), .lane_mrk_bad_i(lane_mrk_bad_i),
  .deskew_done_i(deskew_done_i), .hi_ber_i(hi_ber_i),
  .int_fault_i(int_fault_i), .rcv_local_fault_i(rcv_local_fault_i),
  .lane_word_sync_vector_o(lane_word_sync_vector_o),
  .lane_word_sync_error_vector_o(lane_word_sync_error_vector_o),
  .lane_marker_repeat_error_o(lane_marker_repeat_error_o),
  .lane_marker_word_error_o(lane_marker_word_error_o),
  .ferr_cnt_16_o(ferr_cnt_16_o), .ferr_vld_16_o(ferr_vld_16_o),
  .aligned_o(aligned_o), .pcs_status_o(pcs_status_o),
  .local_fault_o(local_fault_o));

`default_nettype wire

// ==== test/rla_status_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin failures++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end

module rla_status_tb_top;
  logic        mclk_i = 1'b0;
  logic        rst_i  = 1'b1;
  logic [7:0]  addr   = 8'h00;
  logic [31:0] wdata  = 32'h0;
  logic        wr     = 1'b0;
  logic        rd     = 1'b0;
  logic [19:0] word = '0, lock = '0, hdr = '0, lost = '0, good = '0, bad = '0;
  logic        dsk = 0, afl = 0, hib = 0, intf = 0, rlf = 0;
  logic [31:0] rdata, d;
  logic [19:0] blk, syn, serr, len, rep, mfe;
  logic [3:0]  fc16, fc17, fc18, fc19, fv;
  logic        aln, aerr, pst, lf;
  int unsigned mf_seen, nbad = 0, failures = 0, num_checks = 0, cycles = 0;
  int          r;

  always #25 mclk_i = ~mclk_i;

  rla_status u_dut (.mclk_i(mclk_i), .rst_i(rst_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .lane_word_i(word), .lane_blk_lock_i(lock), .lane_hdr_err_i(hdr),
    .lane_sync_lost_i(lost), .lane_mrk_good_i(good), .lane_mrk_bad_i(bad),
    .deskew_done_i(dsk), .align_fault_i(afl), .hi_ber_i(hib),
    .int_fault_i(intf), .rcv_local_fault_i(rlf), .block_lock_o(blk),
    .lane_word_sync_vector_o(syn), .lane_word_sync_error_vector_o(serr),
    .lane_marker_interval_error_o(len), .lane_marker_repeat_error_o(rep),
    .lane_marker_word_error_o(mfe), .ferr_cnt_16_o(fc16),
    .ferr_cnt_17_o(fc17), .ferr_cnt_18_o(fc18), .ferr_cnt_19_o(fc19),
    .ferr_vld_16_o(fv[0]), .ferr_vld_17_o(fv[1]), .ferr_vld_18_o(fv[2]),
    .ferr_vld_19_o(fv[3]), .aligned_o(aln), .aligned_err_o(aerr),
    .pcs_status_o(pst), .local_fault_o(lf));

  rla_user_mon u_mon (.mclk_i(mclk_i), .rst_i(rst_i), .mf_err_i(mfe),
    .mf_seen_o(mf_seen));

  function automatic logic [31:0] exp_aln(logic a, e, i, f);
    return {28'h0, (!a | i | f), (a & !hib), e, a};
  endfunction : exp_aln

  task automatic close_out();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk_i);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge mclk_i);
    wr    <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a);
    @(posedge mclk_i);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk_i);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg

  // Seven plain words, one marker word, then the lanes fall quiet.
  task automatic period(input logic [19:0] g, input logic [19:0] b);
    repeat (7)
    begin
      @(posedge mclk_i);
      word <= '1;
      good <= '0;
      bad  <= '0;
    end
    @(posedge mclk_i);
    good <= g;
    bad  <= b;
    @(posedge mclk_i);
    word <= '0;
    good <= '0;
    bad  <= '0;
    repeat (2) @(posedge mclk_i);
    #1;
  endtask : period

  always @(posedge mclk_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      failures++;
      $display("[ERR] %0t run hung", $time);
      close_out();
    end
  end

  initial
  begin
    void'($urandom(32'h1bf362dd));
    repeat (16) @(posedge mclk_i);
    rst_i <= 1'b0;
    rd_reg(rla_pkg::OFS_SPACING);
    `CHK(d, {16'h0, rla_pkg::RST_SPACING})
    rd_reg(rla_pkg::OFS_ALIGN);
    `CHK(d, exp_aln(0, 0, 0, 0))
    wr_reg(rla_pkg::OFS_SPACING, 32'hffff0007);
    wr_reg(rla_pkg::OFS_ALIGN, 32'hffffffff);
    rd_reg(rla_pkg::OFS_SPACING);
    `CHK(d, 32'h7)
    rd_reg(8'h14);
    `CHK(d, 32'h0)
    lock <= '1;
    dsk  <= 1'b1;
    period('1, '0);
    period('1, '0);
    rd_reg(rla_pkg::OFS_WORD_SYNC);
    `CHK(d, 32'hfffff)
    rd_reg(rla_pkg::OFS_BLOCK_LCK);
    `CHK(d, 32'hfffff)
    `CHK(blk, 20'hfffff)
    rd_reg(rla_pkg::OFS_ALIGN);
    `CHK(d, exp_aln(1, 0, 0, 0))
    $display("test registers and alignment done");
    repeat (16)
    begin
      @(posedge mclk_i);
      {hib, intf, rlf} <= 3'($urandom);
      repeat (2) @(posedge mclk_i);
      #1;
      d = exp_aln(1, 0, intf, rlf);
      `CHK({aln, pst, lf}, {d[0], d[2], d[3]})
    end
    {hib, intf, rlf} <= 3'b000;
    $display("test fault levels done");
    for (int k = 0; k < 4; k++)
    begin
      r = $urandom_range(19);
      nbad += (r == 3) ? 1 : 2;
      period(~(20'h8 | 20'(1 << r)), 20'h8 | 20'(1 << r));
      if (k == 2)
        `CHK(rep[3], 1'b0)
    end
    `CHK(rep[3], 1'b1)
    period('1, '0);
    `CHK(rep[3], 1'b0)
    `CHK(mf_seen, nbad)
    period(~20'h20, '0);
    period('1, '0);
    `CHK(len, 20'h20)
    period('1, '0);
    `CHK(len, 20'h0)
    $display("test marker errors done");
    @(posedge mclk_i);
    hdr <= 20'hf0000;
    @(posedge mclk_i);
    hdr <= '0;
    repeat (20)
    begin
      @(posedge mclk_i);
      #1;
      if (fv[0] === 1'b1)
        break;
    end
    `CHK({fv, fc16, fc17, fc18, fc19}, 20'hf1111)
    @(posedge mclk_i);
    lost <= 20'h1;
    @(posedge mclk_i);
    lost <= '0;
    repeat (3) @(posedge mclk_i);
    #1;
    `CHK({serr[0], syn[0], aln, aerr, lf}, 5'b10011)
    period('1, '0);
    `CHK({serr[0], syn[0], aln, aerr, lf}, 5'b01100)
    $display("test sync loss done");
    lock <= '0;
    dsk  <= 1'b0;
    @(posedge mclk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    #1;
    `CHK({syn, aln, lf}, {20'h0, 2'b01})
    @(posedge mclk_i);
    afl <= 1'b1;
    repeat (2) @(posedge mclk_i);
    #1;
    `CHK(aerr, 1'b1)
    @(posedge mclk_i);
    afl <= 1'b0;
    $display("test second reset done");
    close_out();
  end
endmodule : rla_status_tb_top

`default_nettype wire

// ==== test/rla_user_mon.sv ====
`timescale 1ns/1ps
`default_nettype none

// User logic only listens; it tallies every marker word error pulse.
module rla_user_mon (
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic [19:0] mf_err_i,
  output var int unsigned  mf_seen_o
);
  always_ff @(posedge mclk_i or posedge rst_i)
    if (rst_i)
      mf_seen_o <= 0;
    else
      mf_seen_o <= mf_seen_o + $countones(mf_err_i);
endmodule : rla_user_mon

`default_nettype wire
